//--- core/dtppl_regs.vh
// register indices, control and status fields, reset values of the probe latch
// assumes a single 100 MHz drive clock and cyclic process data exchange
// Behaviour
// - control bits 0/8 enable channel one/two
// - bits 1/9: single-shot or continuous capture
// - bits 2/10: external latch or internal source
// - bits 4/12 enable rising-edge capture
// - bits 5/13 enable falling-edge capture
// - 16-bit control word, resets zero, master zeroes reserved
// - status bits 0/8 show channel enabled
// - status bits 1/9 flag rising-edge capture
// - status bits 2/10 flag falling-edge capture
// - 16-bit read-only status, reserved bits read zero
// - rising capture stores signed 32-bit position
// - falling capture stores signed 32-bit position
`ifndef DTPPL_REGS_VH
`define DTPPL_REGS_VH

`define DTPPL_IDX_CONTROL      16'h60b8
`define DTPPL_IDX_STATUS       16'h60b9
`define DTPPL_IDX_ONE_RISE     16'h60ba
`define DTPPL_IDX_ONE_FALL     16'h60bb
`define DTPPL_IDX_TWO_RISE     16'h60bc
`define DTPPL_IDX_TWO_FALL     16'h60bd

`define DTPPL_CONTROL_RESET    16'h0000

// field positions within one channel's byte of the control word
`define DTPPL_CTL_ENABLE       0
`define DTPPL_CTL_CONTINUOUS   1
`define DTPPL_CTL_SOURCE       2
`define DTPPL_CTL_RISE_EN      4
`define DTPPL_CTL_FALL_EN      5

// field positions within one channel's byte of the status word
`define DTPPL_STS_ENABLED      0
`define DTPPL_STS_RISE_FLAG    1
`define DTPPL_STS_FALL_FLAG    2

// channel two byte offset within both words
`define DTPPL_CH_STRIDE        8

// object selector codes
`define DTPPL_SEL_NONE         3'h0
`define DTPPL_SEL_CONTROL      3'h1
`define DTPPL_SEL_STATUS       3'h2
`define DTPPL_SEL_ONE_RISE     3'h3
`define DTPPL_SEL_ONE_FALL     3'h4
`define DTPPL_SEL_TWO_RISE     3'h5
`define DTPPL_SEL_TWO_FALL     3'h6

`endif

//--- core/dtppl_channel.v
// one probe channel: edge detection on the chosen synchronised trigger and capture
// assumes trigger inputs already pass two flip-flops in the core_clk domain
`timescale 1ns/100ps
`default_nettype none
`include "dtppl_regs.vh"

module dtppl_channel
(
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        enable,
	input  wire        continuous,
	input  wire        source_internal,
	input  wire        rise_en,
	input  wire        fall_en,
	input  wire        ext_trig,
	input  wire        int_trig,
	input  wire [31:0] position_count,
	output reg         rise_flag,
	output reg         fall_flag,
	output reg  [31:0] rise_pos,
	output reg  [31:0] fall_pos
);

	reg  trig_prev;
	reg  src_prev;
	reg  enable_prev;
	reg  armed;
	wire trig_now;
	wire src_stable;
	wire rise_hit;
	wire fall_hit;
	wire enable_rise;

	assign trig_now    = source_internal ? int_trig : ext_trig;
	assign src_stable  = (src_prev == source_internal);
	assign enable_rise = enable & ~enable_prev;
	// edges on the synchronised trigger, masked for a cycle on source change
	assign rise_hit = enable & armed & src_stable & rise_en & trig_now & ~trig_prev;
	assign fall_hit = enable & armed & src_stable & fall_en & ~trig_now & trig_prev;

	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			trig_prev   <= 1'b0;
			src_prev    <= 1'b0;
			enable_prev <= 1'b0;
			armed       <= 1'b0;
			rise_flag   <= 1'b0;
			fall_flag   <= 1'b0;
			rise_pos    <= 32'h00000000;
			fall_pos    <= 32'h00000000;
		end
		else
		begin
			trig_prev   <= trig_now;
			src_prev    <= source_internal;
			enable_prev <= enable;
			// a capture in the re-enable cycle wins over the clear
			if ((rise_hit | fall_hit) & ~continuous)
				armed <= 1'b0;
			else if (enable_rise)
				armed <= 1'b1;
			if (rise_hit)
			begin
				rise_flag <= 1'b1;
				rise_pos  <= position_count;
			end
			else if (enable_rise)
				rise_flag <= 1'b0;
			if (fall_hit)
			begin
				fall_flag <= 1'b1;
				fall_pos  <= position_count;
			end
			else if (enable_rise)
				fall_flag <= 1'b0;
		end
	end

endmodule // dtppl_channel

`default_nettype wire

//--- core/dtppl_top.v
// dual touch-probe position latch with cyclic and indexed object access
// assumes position_count and internal outputs are on core_clk; the external latch is a pin
`timescale 1ns/100ps
`default_nettype none
`include "dtppl_regs.vh"

module dtppl_top
(
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        external_latch_input,
	input  wire        zero_position_output,
	input  wire        step_timing_output,
	input  wire        internal_source_timing,
	input  wire [31:0] position_count,
	input  wire        rx_pdo_valid,
	input  wire [15:0] rx_pdo_control,
	input  wire        od_req,
	input  wire        od_write,
	input  wire [15:0] od_index,
	input  wire [15:0] od_wdata,
	output reg         od_ack,
	output reg         od_error,
	output reg  [31:0] od_rdata,
	output reg  [15:0] probe_control_word,
	output reg  [15:0] probe_status_word,
	output wire [31:0] probe_one_rising_position,
	output wire [31:0] probe_one_falling_position,
	output wire [31:0] probe_two_rising_position,
	output wire [31:0] probe_two_falling_position
);

	// maps an object index to a selector code
	function [2:0] dtppl_decode;
		input [15:0] index;
		begin
			case (index)
				`DTPPL_IDX_CONTROL:  dtppl_decode = `DTPPL_SEL_CONTROL;
				`DTPPL_IDX_STATUS:   dtppl_decode = `DTPPL_SEL_STATUS;
				`DTPPL_IDX_ONE_RISE: dtppl_decode = `DTPPL_SEL_ONE_RISE;
				`DTPPL_IDX_ONE_FALL: dtppl_decode = `DTPPL_SEL_ONE_FALL;
				`DTPPL_IDX_TWO_RISE: dtppl_decode = `DTPPL_SEL_TWO_RISE;
				`DTPPL_IDX_TWO_FALL: dtppl_decode = `DTPPL_SEL_TWO_FALL;
				default:             dtppl_decode = `DTPPL_SEL_NONE;
			endcase
		end
	endfunction

	// packs one channel's status byte, reserved bits zero
	function [7:0] dtppl_status_byte;
		input enabled;
		input rise;
		input fall;
		begin
			dtppl_status_byte                       = 8'h00;
			dtppl_status_byte[`DTPPL_STS_ENABLED]   = enabled;
			dtppl_status_byte[`DTPPL_STS_RISE_FLAG] = rise;
			dtppl_status_byte[`DTPPL_STS_FALL_FLAG] = fall;
		end
	endfunction

	// trigger synchronisers: ext, zero position, timing
	reg  [2:0]  sync_meta;
	reg  [2:0]  sync_stable;
	reg         int_sel_meta;
	reg         int_sel_stable;
	wire        int_trig;
	wire [1:0]  rise_flag;
	wire [1:0]  fall_flag;
	wire [31:0] rise_pos [0:1];
	wire [31:0] fall_pos [0:1];
	wire [2:0]  od_sel;
	wire        od_ctl_write;
	reg  [15:0] next_control;
	reg  [15:0] next_status;
	reg  [31:0] next_rdata;
	reg         next_error;

	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			sync_meta      <= 3'h0;
			sync_stable    <= 3'h0;
			int_sel_meta   <= 1'b0;
			int_sel_stable <= 1'b0;
		end
		else
		begin
			sync_meta      <= {step_timing_output, zero_position_output, external_latch_input};
			sync_stable    <= sync_meta;
			int_sel_meta   <= internal_source_timing;
			int_sel_stable <= int_sel_meta;
		end
	end

	// internal source: zero-position output or step timing output
	assign int_trig = int_sel_stable ? sync_stable[2] : sync_stable[1];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1)
		begin : g_channel
			dtppl_channel u_channel
			(
				.core_clk        (core_clk),
				.rst_n           (rst_n),
				.enable          (probe_control_word[ch*`DTPPL_CH_STRIDE + `DTPPL_CTL_ENABLE]),
				.continuous      (probe_control_word[ch*`DTPPL_CH_STRIDE + `DTPPL_CTL_CONTINUOUS]),
				.source_internal (probe_control_word[ch*`DTPPL_CH_STRIDE + `DTPPL_CTL_SOURCE]),
				.rise_en         (probe_control_word[ch*`DTPPL_CH_STRIDE + `DTPPL_CTL_RISE_EN]),
				.fall_en         (probe_control_word[ch*`DTPPL_CH_STRIDE + `DTPPL_CTL_FALL_EN]),
				.ext_trig        (sync_stable[0]),
				.int_trig        (int_trig),
				.position_count  (position_count),
				.rise_flag       (rise_flag[ch]),
				.fall_flag       (fall_flag[ch]),
				.rise_pos        (rise_pos[ch]),
				.fall_pos        (fall_pos[ch])
			);
		end
	endgenerate

	assign probe_one_rising_position  = rise_pos[0];
	assign probe_one_falling_position = fall_pos[0];
	assign probe_two_rising_position  = rise_pos[1];
	assign probe_two_falling_position = fall_pos[1];

	assign od_sel       = dtppl_decode(od_index);
	assign od_ctl_write = od_req & od_write & (od_sel == `DTPPL_SEL_CONTROL);

	// control word: cyclic data wins over an indexed write in the same cycle
	always @*
	begin
		next_control = probe_control_word;
		if (rx_pdo_valid)
			next_control = rx_pdo_control;
		else if (od_ctl_write)
			next_control = od_wdata;
	end

	// status word, reserved bits held at zero
	always @*
	begin
		next_status = 16'h0000;
		next_status[0 +: `DTPPL_CH_STRIDE] =
			dtppl_status_byte(probe_control_word[`DTPPL_CTL_ENABLE], rise_flag[0], fall_flag[0]);
		next_status[`DTPPL_CH_STRIDE +: `DTPPL_CH_STRIDE] =
			dtppl_status_byte(probe_control_word[`DTPPL_CH_STRIDE + `DTPPL_CTL_ENABLE], rise_flag[1], fall_flag[1]);
	end

	// indexed read mux and error answer
	always @*
	begin
		next_rdata = 32'h00000000;
		next_error = 1'b0;
		case (od_sel)
			`DTPPL_SEL_CONTROL:
			begin
				next_rdata = {16'h0000, probe_control_word};
				next_error = 1'b0;
			end
			`DTPPL_SEL_STATUS:
			begin
				next_rdata = {16'h0000, probe_status_word};
				next_error = od_write;
			end
			`DTPPL_SEL_ONE_RISE:
			begin
				next_rdata = rise_pos[0];
				next_error = od_write;
			end
			`DTPPL_SEL_ONE_FALL:
			begin
				next_rdata = fall_pos[0];
				next_error = od_write;
			end
			`DTPPL_SEL_TWO_RISE:
			begin
				next_rdata = rise_pos[1];
				next_error = od_write;
			end
			`DTPPL_SEL_TWO_FALL:
			begin
				next_rdata = fall_pos[1];
				next_error = od_write;
			end
			default:
			begin
				next_rdata = 32'h00000000;
				next_error = 1'b1;
			end
		endcase
	end

	// control and status words
	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			probe_control_word <= `DTPPL_CONTROL_RESET;
			probe_status_word  <= 16'h0000;
		end
		else
		begin
			probe_control_word <= next_control;
			probe_status_word  <= next_status;
		end
	end

	// indexed access answer, one cycle after the request
	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			od_ack   <= 1'b0;
			od_error <= 1'b0;
			od_rdata <= 32'h00000000;
		end
		else
		begin
			od_ack   <= od_req;
			od_error <= od_req & next_error;
			if (od_req)
				od_rdata <= next_rdata;
		end
	end

endmodule // dtppl_top

`default_nettype wire

//--- tb/dtppl_checker.sv
// port assertions for the dual probe latch top
// assumes one core_clk domain and the register header on the include path
`timescale 1ns/100ps
`default_nettype none
`include "dtppl_regs.vh"
module dtppl_checker (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        rx_pdo_valid,
	input wire logic [15:0] rx_pdo_control,
	input wire logic        od_req,
	input wire logic        od_write,
	input wire logic [15:0] od_index,
	input wire logic        od_ack,
	input wire logic        od_error,
	input wire logic [15:0] probe_control_word,
	input wire logic [15:0] probe_status_word,
	input wire logic [31:0] probe_one_rising_position,
	input wire logic [31:0] probe_one_falling_position
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_ro_wr; od_req && od_write && od_index == `DTPPL_IDX_STATUS; endsequence
	sequence s_shot; probe_status_word[1] && probe_control_word[1:0] == 2'b01; endsequence
	property p_ack; od_req |=> od_ack; endproperty
	a_ack: assert property (p_ack) else $error("request not acknowledged");
	property p_ctl; rx_pdo_valid |=> probe_control_word == $past(rx_pdo_control); endproperty
	a_ctl: assert property (p_ctl) else $error("cyclic control write lost");
	property p_rsv; probe_status_word[7:3] == 5'h0 && probe_status_word[15:11] == 5'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bit set");
	property p_en; probe_status_word[0] == $past(probe_control_word[0]) && probe_status_word[8] == $past(probe_control_word[8]); endproperty
	a_en: assert property (p_en) else $error("enable status wrong");
	property p_ro; s_ro_wr |=> od_ack && od_error; endproperty
	a_ro: assert property (p_ro) else $error("status write not refused");
	property p_unmap; od_req && od_index > `DTPPL_IDX_TWO_FALL |=> od_error; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped index accepted");
	property p_rise; $changed(probe_one_rising_position) |-> $past(probe_control_word[4]) && $past(probe_control_word[0]); endproperty
	a_rise: assert property (p_rise) else $error("rising capture while off");
	property p_fall; $changed(probe_one_falling_position) |-> $past(probe_control_word[5]) && $past(probe_control_word[0]); endproperty
	a_fall: assert property (p_fall) else $error("falling capture while off");
	property p_shot; s_shot ##0 probe_control_word == $past(probe_control_word, 4) |=> $stable(probe_one_falling_position); endproperty
	a_shot: assert property (p_shot) else $error("second single-shot capture");
endmodule // dtppl_checker
bind dtppl_top dtppl_checker u_chk (
	.core_clk                   (core_clk),
	.rst_n                      (rst_n),
	.rx_pdo_valid               (rx_pdo_valid),
	.rx_pdo_control             (rx_pdo_control),
	.od_req                     (od_req),
	.od_write                   (od_write),
	.od_index                   (od_index),
	.od_ack                     (od_ack),
	.od_error                   (od_error),
	.probe_control_word         (probe_control_word),
	.probe_status_word          (probe_status_word),
	.probe_one_rising_position  (probe_one_rising_position),
	.probe_one_falling_position (probe_one_falling_position)
);
`default_nettype wire

//--- tb/dtppl_master.sv
// fieldbus master model: cyclic control word writes
// assumes core_clk from the bench
`timescale 1ns/100ps
`default_nettype none
module dtppl_master (
	input wire logic        core_clk,
	output var logic        rx_pdo_valid,
	output var logic [15:0] rx_pdo_control
);
	initial {rx_pdo_valid, rx_pdo_control} = 17'h0;
	task automatic send(input logic [15:0] w);
		@(posedge core_clk);
		#1;
		rx_pdo_valid = 1;
		rx_pdo_control = w & 16'h3737;
		@(posedge core_clk);
		#1;
		rx_pdo_valid = 0;
		rx_pdo_control = ~rx_pdo_control;
	endtask
endmodule // dtppl_master
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the dual probe latch
// assumes design files and the master model compile first
`timescale 1ns/100ps
`default_nettype none
`include "dtppl_regs.vh"
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
	logic        core_clk = 0, rst_n = 0, od_req = 0, od_write = 0, internal_source_timing = 0;
	logic [2:0]  trig = 0;
	logic [31:0] position_count = 0;
	logic [15:0] od_index = 0, od_wdata = 0, ctl = 0, fl = 0;
	logic [33:0] q[$], x;
	logic [31:0] xp[4] = '{default:0};
	int          failures = 0, comparisons = 0, cyc = 0;
	wire         od_ack, od_error, rx_pdo_valid, external_latch_input, zero_position_output, step_timing_output;
	wire  [31:0] od_rdata, probe_one_rising_position, probe_one_falling_position;
	wire  [31:0] probe_two_rising_position, probe_two_falling_position;
	wire  [15:0] rx_pdo_control, probe_control_word, probe_status_word;
	wire [127:0] pos_all;
	assign {step_timing_output, zero_position_output, external_latch_input} = trig;
	assign pos_all = {probe_two_falling_position, probe_two_rising_position,
		probe_one_falling_position, probe_one_rising_position};
	dtppl_top u_dut
	(
		.core_clk                   (core_clk),
		.rst_n                      (rst_n),
		.external_latch_input       (external_latch_input),
		.zero_position_output       (zero_position_output),
		.step_timing_output         (step_timing_output),
		.internal_source_timing     (internal_source_timing),
		.position_count             (position_count),
		.rx_pdo_valid               (rx_pdo_valid),
		.rx_pdo_control             (rx_pdo_control),
		.od_req                     (od_req),
		.od_write                   (od_write),
		.od_index                   (od_index),
		.od_wdata                   (od_wdata),
		.od_ack                     (od_ack),
		.od_error                   (od_error),
		.od_rdata                   (od_rdata),
		.probe_control_word         (probe_control_word),
		.probe_status_word          (probe_status_word),
		.probe_one_rising_position  (probe_one_rising_position),
		.probe_one_falling_position (probe_one_falling_position),
		.probe_two_rising_position  (probe_two_rising_position),
		.probe_two_falling_position (probe_two_falling_position)
	);
	dtppl_master u_mst (.core_clk(core_clk), .rx_pdo_valid(rx_pdo_valid), .rx_pdo_control(rx_pdo_control));
	always #5 core_clk = ~core_clk;
	always @(negedge core_clk)
		if (od_ack === 1'b1)
		begin
			x = q.pop_front();
			if (x[33]) `CHK("od_error", 1'b1, od_error)
			else `CHK("od_answer", x[32:0], {od_error, od_rdata})
		end
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			end_sim();
		end
	end
	task automatic od(input logic w, input logic [15:0] i, input logic [15:0] d, input logic [33:0] e);
		@(posedge core_clk);
		#1;
		q.push_back(e);
		{od_req, od_write, od_index, od_wdata} = {1'b1, w, i, d};
		@(posedge core_clk);
		#1;
		{od_req, od_index, od_wdata} = {1'b0, ~i, ~d};
	endtask
	task automatic cfg(input int ch, input int s, input logic [7:0] b);
		ctl = {8'h0, b | 8'h01 | (s > 0 ? 8'h04 : 8'h00)} << (8 * ch);
		internal_source_timing = (s == 2);
		u_mst.send(16'h0);
		u_mst.send(ctl);
		fl[8 * ch + 1 +: 2] = 2'b00;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	task automatic pulse(input int ch, input int s, input logic v, input logic hit);
		int k;
		k = 2 * ch + (v ? 0 : 1);
		position_count = $urandom;
		trig[s] = v;
		repeat (6) @(posedge core_clk);
		#1;
		if (hit)
		begin
			xp[k] = position_count;
			fl[8 * ch + (v ? 1 : 2)] = 1'b1;
		end
		`CHK("pos_out", xp[k], pos_all[32 * k +: 32])
		`CHK("status_out", fl | (ctl & 16'h0101), probe_status_word)
		od(0, 16'(`DTPPL_IDX_ONE_RISE + k), 16'h0, {2'b00, xp[k]});
		od(0, `DTPPL_IDX_STATUS, 16'h0, {18'h0, fl | (ctl & 16'h0101)});
	endtask
	task automatic end_sim();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		void'($urandom(46638));
		repeat (12) @(posedge core_clk);
		#1;
		rst_n = 1;
		od(0, `DTPPL_IDX_CONTROL, 16'h0, 34'h0);
		od(0, `DTPPL_IDX_STATUS, 16'h0, 34'h0);
		od(0, 16'h60be, 16'h0, {2'b10, 32'h0});
		od(1, `DTPPL_IDX_STATUS, 16'h0101, {2'b10, 32'h0});
		ctl = $urandom & 16'h3737;
		od(1, `DTPPL_IDX_CONTROL, ctl, 34'h0);
		od(0, `DTPPL_IDX_CONTROL, 16'h0, {18'h0, ctl});
		od(0, `DTPPL_IDX_STATUS, 16'h0, {18'h0, ctl & 16'h0101});
		for (int ch = 0; ch < 2; ch++)
			for (int s = 0; s < 3; s++)
			begin
				cfg(ch, s, 8'h32);
				for (int v = 1; v >= 0; v--) pulse(ch, (s + 1) % 3, v, 0);
				repeat (2) for (int v = 1; v >= 0; v--) pulse(ch, s, v, 1);
			end
		cfg(0, 0, 8'h30);
		pulse(0, 0, 1, 1);
		pulse(0, 0, 0, 0);
		cfg(0, 0, 8'h30);
		pulse(0, 0, 1, 1);
		cfg(1, 1, 8'h22);
		pulse(1, 1, 1, 0);
		pulse(1, 1, 0, 1);
		cfg(0, 2, 8'h12);
		pulse(0, 2, 1, 1);
		pulse(0, 2, 0, 0);
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
